// >>> design/fsb_guard.v
// Security decision for one flash command.
// Assumes op, address, mode and flags are stable while it is evaluated.
`timescale 1ns/1ps
`default_nettype none
`include "fsb_regs.vh"

module fsb_guard (
  input  wire [2:0]  op,
  input  wire [15:0] addr,
  input  wire        selfProg,
  input  wire [3:0]  flags,
  output reg         allow
);

  function inBoot0;
    input [15:0] a;
    begin
      inBoot0 = (a[15:12] == `FSB_CLUSTER0_TOP);
    end
  endfunction

  always @* begin
    allow = 1'b1;
    case (op)
      `FSB_OP_CHIP: begin
        // Chip erase has no self-programming form
        if (selfProg)
          allow = 1'b0;
        if (flags[`FSB_F_NOCHIP])
          allow = 1'b0;
        if (flags[`FSB_F_BOOT0])
          allow = 1'b0;
      end
      `FSB_OP_BLOCK: begin
        if (flags[`FSB_F_BOOT0] && inBoot0(addr))
          allow = 1'b0;
        if (!selfProg && flags[`FSB_F_NOCHIP])
          allow = 1'b0;
        if (!selfProg && flags[`FSB_F_NOBLOCK])
          allow = 1'b0;
      end
      `FSB_OP_WRITE: begin
        if (flags[`FSB_F_BOOT0] && inBoot0(addr))
          allow = 1'b0;
        if (!selfProg && flags[`FSB_F_NOWRITE])
          allow = 1'b0;
      end
      default: begin
        allow = 1'b1;
      end
    endcase
  end

endmodule

`default_nettype wire

// >>> design/fsb_reset_sync.v
// Reset release synchroniser: asserts at once, releases after two clocks.
// Assumes rstn may drop at any time relative to clock.
`timescale 1ns/1ps
`default_nettype none

module fsb_reset_sync (
  input  wire clock,
  input  wire rstn,
  output wire rstSyncN
);

  reg stage1;
  reg stage2;

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
    end else begin
      stage1 <= 1'b1;
      stage2 <= stage1;
    end
  end

  assign rstSyncN = stage2;

endmodule

`default_nettype wire

// >>> design/fsb_top.v
// Flash security gate and boot cluster swap, top level.
// Assumes a programmer or firmware front end that hands over decoded commands,
// a nonvolatile store that presents saved flags while reset is released,
// and flash timing logic that acts on the execute strobes.
`timescale 1ns/1ps
`default_nettype none
`include "fsb_regs.vh"

module fsb_top (
  input  wire        clock,
  input  wire        rstn,
  input  wire [3:0]  regAddr,
  input  wire [7:0]  regWData,
  input  wire        regWrite,
  input  wire        regRead,
  output reg  [7:0]  regRData,
  output wire        irq,
  input  wire        cmdValid,
  output wire        cmdReady,
  input  wire [2:0]  cmdOp,
  input  wire [15:0] cmdAddr,
  input  wire [7:0]  cmdData,
  input  wire        cmdSelf,
  output reg         rspAck,
  output reg         rspNak,
  output reg         doChipErase,
  output reg         doBlockErase,
  output reg         doWrite,
  output reg  [15:0] opAddr,
  input  wire [4:0]  nvLoad,
  output wire        nvStore,
  output reg  [4:0]  nvData,
  input  wire [15:0] fetchAddr,
  output reg  [15:0] mappedAddr,
  output wire        bootSwapped
);

  localparam [2:0] ST_LOAD  = 3'b001;
  localparam [2:0] ST_IDLE  = 3'b010;
  localparam [2:0] ST_STORE = 3'b100;

  wire        rstSyncN;
  wire        allow;

  reg  [2:0]  state;
  reg  [2:0]  next_state;
  reg  [3:0]  flags;
  reg  [3:0]  next_flags;
  reg         bootFlag;
  reg         next_bootFlag;
  reg         swapActive;
  reg  [2:0]  status;
  reg  [2:0]  mask;
  reg  [7:0]  nakCount;
  reg  [3:0]  lastCmd;

  wire        cmdTake;
  wire        accept;
  wire        refuse;
  wire        changed;
  wire [2:0]  statusSet;
  wire [2:0]  statusClr;

  // Maps a fetch address through the swap window of clusters 0 and 1
  function [15:0] swapMap;
    input [15:0] a;
    input        swap;
    begin
      if (swap && a[15:13] == `FSB_SWAP_WIN_TOP)
        swapMap = a ^ `FSB_CLUSTER1_BIT;
      else
        swapMap = a;
    end
  endfunction

  fsb_reset_sync uResetSync (
    .clock    (clock),
    .rstn     (rstn),
    .rstSyncN (rstSyncN)
  );

  fsb_guard uGuard (
    .op       (cmdOp),
    .addr     (cmdAddr),
    .selfProg (cmdSelf),
    .flags    (flags),
    .allow    (allow)
  );

  // Commands are only taken when the block is idle; the source waits otherwise
  assign cmdReady = state[1];
  assign cmdTake  = cmdValid & cmdReady;
  assign accept   = cmdTake & allow;
  assign refuse   = cmdTake & ~allow;

  // Flag update from accepted commands
  always @* begin
    next_flags    = flags;
    next_bootFlag = bootFlag;
    if (accept) begin
      case (cmdOp)
        `FSB_OP_SECSET: begin
          // Set only ever adds bits; only a non-self chip erase drops locks, the FSB_CLEARABLE bits
          next_flags = flags | cmdData[3:0];
        end
        `FSB_OP_CHIP: begin
          if (!cmdSelf)
            next_flags = flags & ~`FSB_CLEARABLE;
        end
        `FSB_OP_BOOTSET: begin
          next_bootFlag = cmdData[0];
        end
        default: begin
          next_flags    = flags;
          next_bootFlag = bootFlag;
        end
      endcase
    end
  end

  assign changed = accept & ({next_bootFlag, next_flags} != {bootFlag, flags});

  // Sequencer: load saved state once after reset, then serve commands
  always @* begin
    next_state = state;
    case (state)
      ST_LOAD: begin
        next_state = ST_IDLE;
      end
      ST_IDLE: begin
        if (changed)
          next_state = ST_STORE;
      end
      ST_STORE: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_LOAD;
      end
    endcase
  end

  always @(posedge clock or negedge rstSyncN) begin
    if (!rstSyncN)
      state <= ST_LOAD;
    else
      state <= next_state;
  end

  // Security and boot state; saved values are caught after reset release
  always @(posedge clock or negedge rstSyncN) begin
    if (!rstSyncN) begin
      flags      <= `FSB_FLAGS_RST;
      bootFlag   <= 1'b0;
      swapActive <= 1'b0;
    end else if (state[0]) begin
      flags      <= nvLoad[3:0];
      bootFlag   <= nvLoad[4];
      swapActive <= nvLoad[4];
    end else begin
      flags    <= next_flags;
      bootFlag <= next_bootFlag;
    end
  end

  // The swap only follows the boot flag across a reset, so a half-done
  // rewrite of cluster 0 never changes the live map under running code
  assign bootSwapped = swapActive;

  always @(posedge clock or negedge rstSyncN) begin
    if (!rstSyncN)
      mappedAddr <= `FSB_ADDR_RST;
    else
      mappedAddr <= swapMap(fetchAddr, swapActive);
  end

  // Nonvolatile write-back of changed flags
  assign nvStore = state[2];

  always @(posedge clock or negedge rstSyncN) begin
    if (!rstSyncN)
      nvData <= 5'h00;
    else if (changed)
      nvData <= {next_bootFlag, next_flags};
  end

  // Answer and execute strobes, one cycle after the command is taken
  always @(posedge clock or negedge rstSyncN) begin
    if (!rstSyncN) begin
      rspAck       <= 1'b0;
      rspNak       <= 1'b0;
      doChipErase  <= 1'b0;
      doBlockErase <= 1'b0;
      doWrite      <= 1'b0;
      opAddr       <= `FSB_ADDR_RST;
    end else begin
      rspAck       <= accept;
      rspNak       <= refuse;
      doChipErase  <= accept & (cmdOp == `FSB_OP_CHIP);
      doBlockErase <= accept & (cmdOp == `FSB_OP_BLOCK);
      doWrite      <= accept & (cmdOp == `FSB_OP_WRITE);
      if (cmdTake)
        opAddr <= cmdAddr;
    end
  end

  // Refusal counter saturates so software never sees it wrap to zero
  always @(posedge clock or negedge rstSyncN) begin
    if (!rstSyncN) begin
      nakCount <= 8'h00;
      lastCmd  <= 4'h0;
    end else begin
      if (regWrite && regAddr == `FSB_ADDR_NAKCNT)
        nakCount <= 8'h00;
      else if (refuse && nakCount != 8'hFF)
        nakCount <= nakCount + 8'h01;
      if (cmdTake)
        lastCmd <= {allow, cmdOp};
    end
  end

  // Sticky event bits; a new event wins over a write-one clear
  assign statusSet[`FSB_ST_ACK]  = accept;
  assign statusSet[`FSB_ST_NAK]  = refuse;
  assign statusSet[`FSB_ST_FLAG] = changed;
  assign statusClr = (regWrite && regAddr == `FSB_ADDR_STATUS) ? regWData[2:0] : 3'h0;

  always @(posedge clock or negedge rstSyncN) begin
    if (!rstSyncN) begin
      status <= `FSB_STATUS_RST;
      mask   <= `FSB_MASK_RST;
    end else begin
      status <= (status & ~statusClr) | statusSet;
      if (regWrite && regAddr == `FSB_ADDR_MASK)
        mask <= regWData[2:0];
    end
  end

  assign irq = |(status & mask);

  // Register read port: data stand in the cycle after the strobe only
  always @(posedge clock or negedge rstSyncN) begin
    if (!rstSyncN) begin
      regRData <= 8'h00;
    end else if (regRead) begin
      case (regAddr)
        `FSB_ADDR_STATUS:  regRData <= {5'h00, status};
        `FSB_ADDR_MASK:    regRData <= {5'h00, mask};
        `FSB_ADDR_FLAGS:   regRData <= {4'h0, flags};
        `FSB_ADDR_BOOT:    regRData <= {6'h00, swapActive, bootFlag};
        `FSB_ADDR_NAKCNT:  regRData <= nakCount;
        `FSB_ADDR_LASTCMD: regRData <= {4'h0, lastCmd};
        default:           regRData <= 8'h00;
      endcase
    end else begin
      regRData <= 8'h00;
    end
  end

  // Software ordering of boot image updates is left to firmware
  // Blank-area discipline under a chip-erase lock is left to the programmer

endmodule

`default_nettype wire

// >>> inc/fsb_regs.vh
// Constants for the flash security gate and boot swap block.
// Assumes an 8-bit register port with a 4-bit word address.
`ifndef FSB_REGS_VH
`define FSB_REGS_VH

// Register addresses
`define FSB_ADDR_STATUS   4'h0
`define FSB_ADDR_MASK     4'h1
`define FSB_ADDR_FLAGS    4'h2
`define FSB_ADDR_BOOT     4'h3
`define FSB_ADDR_NAKCNT   4'h4
`define FSB_ADDR_LASTCMD  4'h5

// Security flag bit positions
`define FSB_F_NOCHIP      0
`define FSB_F_NOBLOCK     1
`define FSB_F_NOWRITE     2
`define FSB_F_BOOT0       3
`define FSB_FLAGS_RST     4'h0
`define FSB_CLEARABLE     4'h6

// Status bit positions
`define FSB_ST_ACK        0
`define FSB_ST_NAK        1
`define FSB_ST_FLAG       2
`define FSB_STATUS_RST    3'h0
`define FSB_MASK_RST      3'h0

// Command codes
`define FSB_OP_CHIP       3'h1
`define FSB_OP_BLOCK      3'h2
`define FSB_OP_WRITE      3'h3
`define FSB_OP_SECSET     3'h4
`define FSB_OP_BOOTSET    3'h5

// Boot cluster layout: two 4 KB clusters at the bottom of flash
`define FSB_CLUSTER0_TOP  4'h0
`define FSB_SWAP_WIN_TOP  3'h0
`define FSB_CLUSTER1_BIT  16'h1000
`define FSB_ADDR_RST      16'h0000

`endif

// >>> test/fsb_prog_model.sv
// Model of the external programmer or self-programming firmware.
// Assumes a command is taken at a rising edge with valid and ready high.
`timescale 1ns/1ps
`default_nettype none

module fsb_prog_model (
  input  wire logic        clock,
  input  wire logic        cmdReady,
  input  wire logic        rspAck,
  input  wire logic        rspNak,
  output var  logic        cmdValid,
  output var  logic [2:0]  cmdOp,
  output var  logic [15:0] cmdAddr,
  output var  logic [7:0]  cmdData,
  output var  logic        cmdSelf
);
  int gap = 0;

  initial begin
    cmdValid = 1'b0;
    cmdOp = 3'h0;
    cmdAddr = 16'h0000;
    cmdData = 8'h00;
    cmdSelf = 1'b0;
  end

  // Only this side starts work; the block merely answers
  // Same path sets flags in both modes
  task automatic send(input logic [2:0] op, input logic [15:0] a, input logic [7:0] d,
                      input logic s, output logic ack, output logic nak);
    repeat (gap) @(posedge clock);
    @(posedge clock);
    cmdValid <= 1'b1;
    cmdOp <= op;
    cmdAddr <= a;
    cmdData <= d;
    cmdSelf <= s;
    #1;
    while (!cmdReady) begin
      @(posedge clock);
      #1;
    end
    @(posedge clock);
    // Op, address and data inverted on release (cmdSelf kept), so a stale value never passes as live
    cmdValid <= 1'b0;
    cmdOp <= ~op;
    cmdAddr <= ~a;
    cmdData <= ~d;
    #1;
    ack = rspAck;
    nak = rspNak;
  endtask
endmodule
`default_nettype wire

// >>> test/fsb_tb_top.sv
// Self-checking bench for the flash security gate and boot swap.
// Assumes the programmer model drives commands; the bench owns registers.
`timescale 1ns/1ps
`default_nettype none
`include "fsb_regs.vh"
`define CHK(g, e) begin cmpCount++; if ((g) !== (e)) begin nFail++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, (g), (e)); end end

module tb_top;
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic        regWrite = 1'b0;
  logic        regRead = 1'b0;
  logic [3:0]  regAddr = 4'h0;
  logic [7:0]  regWData = 8'h00;
  logic [4:0]  nvLoad = 5'h00;
  logic [15:0] fetchAddr = 16'h0000;
  logic [7:0]  regRData, cmdData;
  logic [2:0]  cmdOp;
  logic [15:0] cmdAddr, opAddr, mappedAddr;
  logic [4:0]  nvData;
  logic        irq, cmdValid, cmdReady, cmdSelf, rspAck, rspNak;
  logic        doChip, doBlock, doWr, nvStore, bootSwapped;
  int          nFail = 0;
  int          cmpCount = 0;

  initial begin
    forever #2.5 clock = ~clock;
  end

  fsb_top dut (.clock(clock), .rstn(rstn), .regAddr(regAddr), .regWData(regWData),
    .regWrite(regWrite), .regRead(regRead), .regRData(regRData), .irq(irq),
    .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdOp(cmdOp), .cmdAddr(cmdAddr),
    .cmdData(cmdData), .cmdSelf(cmdSelf), .rspAck(rspAck), .rspNak(rspNak),
    .doChipErase(doChip), .doBlockErase(doBlock), .doWrite(doWr), .opAddr(opAddr),
    .nvLoad(nvLoad), .nvStore(nvStore), .nvData(nvData), .fetchAddr(fetchAddr),
    .mappedAddr(mappedAddr), .bootSwapped(bootSwapped));

  fsb_prog_model prog (.clock(clock), .cmdReady(cmdReady), .rspAck(rspAck),
    .rspNak(rspNak), .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdAddr(cmdAddr),
    .cmdData(cmdData), .cmdSelf(cmdSelf));

  task automatic wrapUp;
    if (nFail == 0 && cmpCount > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic doReset(input logic [4:0] nv);
    @(posedge clock);
    rstn <= 1'b0;
    nvLoad <= nv;
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    repeat (6) @(posedge clock);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    regWrite <= 1'b1;
    regAddr <= a;
    regWData <= d;
    @(posedge clock);
    regWrite <= 1'b0;
    #1;
  endtask

  task automatic rdChk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clock);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'b0;
    #1 `CHK(regRData, e)
  endtask

  task automatic cmd(input logic [2:0] op, input logic [15:0] a, input logic [7:0] d,
                     input logic s, input logic e);
    logic ack, nak;
    prog.send(op, a, d, s, ack, nak);
    `CHK({ack, nak}, {e, !e})
  endtask

  task automatic mapChk(input logic [15:0] a, input logic [15:0] e);
    @(posedge clock);
    fetchAddr <= a;
    @(posedge clock);
    #1 `CHK(mappedAddr, e)
  endtask

  initial begin
    doReset(5'h00);
    rdChk(`FSB_ADDR_FLAGS, 8'h00);
    mapChk(16'h0123, 16'h0123);
    cmd(`FSB_OP_WRITE, 16'h2000, 8'h5A, 1'b0, 1'b1);
    cmd(`FSB_OP_SECSET, 16'h0000, 8'h06, 1'b0, 1'b1);
    `CHK(nvData, 5'h06)
    rdChk(`FSB_ADDR_FLAGS, 8'h06);
    cmd(`FSB_OP_BLOCK, 16'h2000, 8'h00, 1'b0, 1'b0);
    cmd(`FSB_OP_WRITE, 16'h2000, 8'h00, 1'b0, 1'b0);
    prog.gap = 3;
    cmd(`FSB_OP_BLOCK, 16'h2000, 8'h00, 1'b1, 1'b1);
    cmd(`FSB_OP_WRITE, 16'h2400, 8'h00, 1'b1, 1'b1);
    cmd(`FSB_OP_CHIP, 16'h0000, 8'h00, 1'b1, 1'b0);
    rdChk(`FSB_ADDR_FLAGS, 8'h06);
    prog.gap = 0;
    cmd(`FSB_OP_CHIP, 16'h0000, 8'h00, 1'b0, 1'b1);
    rdChk(`FSB_ADDR_FLAGS, 8'h00);
    cmd(`FSB_OP_SECSET, 16'h0000, 8'h01, 1'b0, 1'b1);
    cmd(`FSB_OP_BLOCK, 16'h2000, 8'h00, 1'b0, 1'b0);
    cmd(`FSB_OP_WRITE, 16'h3000, 8'h00, 1'b0, 1'b1);
    cmd(`FSB_OP_CHIP, 16'h0000, 8'h00, 1'b0, 1'b0);
    cmd(`FSB_OP_SECSET, 16'h0000, 8'h06, 1'b1, 1'b1);
    rdChk(`FSB_ADDR_FLAGS, 8'h07);
    cmd(`FSB_OP_WRITE, 16'h1000, 8'h00, 1'b1, 1'b1);
    cmd(`FSB_OP_SECSET, 16'h0000, 8'h08, 1'b1, 1'b1);
    cmd(`FSB_OP_BLOCK, 16'h0800, 8'h00, 1'b1, 1'b0);
    cmd(`FSB_OP_WRITE, 16'h0100, 8'h00, 1'b1, 1'b0);
    cmd(`FSB_OP_BLOCK, 16'h1000, 8'h00, 1'b1, 1'b1);
    cmd(`FSB_OP_CHIP, 16'h0000, 8'h00, 1'b0, 1'b0);
    wr(`FSB_ADDR_FLAGS, 8'h00);
    rdChk(`FSB_ADDR_FLAGS, 8'h0F);
    rdChk(`FSB_ADDR_NAKCNT, 8'h08);
    rdChk(4'hF, 8'h00);
    rdChk(`FSB_ADDR_STATUS, 8'h07);
    `CHK(irq, 1'b0)
    wr(`FSB_ADDR_MASK, 8'h02);
    `CHK(irq, 1'b1)
    wr(`FSB_ADDR_STATUS, 8'h07);
    `CHK(irq, 1'b0)
    rdChk(`FSB_ADDR_STATUS, 8'h00);
    cmd(`FSB_OP_BOOTSET, 16'h0000, 8'h01, 1'b1, 1'b1);
    `CHK(nvData, 5'h1F)
    rdChk(`FSB_ADDR_BOOT, 8'h01);
    `CHK(bootSwapped, 1'b0)
    doReset(5'h19);
    rdChk(`FSB_ADDR_FLAGS, 8'h09);
    rdChk(`FSB_ADDR_BOOT, 8'h03);
    mapChk(16'h0123, 16'h1123);
    mapChk(16'h1FFF, 16'h0FFF);
    mapChk(16'h2000, 16'h2000);
    cmd(`FSB_OP_BOOTSET, 16'h0000, 8'h00, 1'b1, 1'b1);
    rdChk(`FSB_ADDR_BOOT, 8'h02);
    wrapUp;
  end

  initial begin
    #20000;
    nFail++;
    wrapUp;
  end
endmodule
`default_nettype wire

// >>> test/fsb_top_properties.sv
// Port checks for the flash security gate and boot swap.
// Assumes it is bound into fsb_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
`include "fsb_regs.vh"

module fsb_top_props (
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic        cmdValid,
  input wire logic        cmdReady,
  input wire logic [2:0]  cmdOp,
  input wire logic [15:0] cmdAddr,
  input wire logic        cmdSelf,
  input wire logic        rspAck,
  input wire logic        rspNak,
  input wire logic        doChipErase,
  input wire logic        doBlockErase,
  input wire logic        doWrite,
  input wire logic [15:0] opAddr,
  input wire logic        nvStore,
  input wire logic [15:0] fetchAddr,
  input wire logic [15:0] mappedAddr,
  input wire logic        bootSwapped
);
  logic [2:0] upCnt;
  logic       up;
  logic       take;

  // Skip sync release and load cycle, where outputs are still held
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      upCnt <= 3'h0;
    end else if (upCnt != 3'h7) begin
      upCnt <= upCnt + 3'h1;
    end
  end
  assign up = (upCnt == 3'h7);
  assign take = up && cmdValid && cmdReady;

  default clocking @(posedge clock);
  endclocking
  default disable iff (!rstn);

  a_one_answer: assert property (
    take |=> rspAck != rspNak) else $error("not one answer");
  a_ack_nak_excl: assert property (
    !(rspAck && rspNak)) else $error("ack and nak together");
  a_self_chip: assert property (
    take && cmdSelf && cmdOp == `FSB_OP_CHIP |=> rspNak) else $error("self chip erase ran");
  a_strobe_ack: assert property (
    doChipErase || doBlockErase || doWrite |-> rspAck) else $error("strobe without ack");
  a_write_exec: assert property (
    take && cmdOp == `FSB_OP_WRITE |=> doWrite == rspAck && !doBlockErase)
    else $error("write strobe wrong");
  a_chip_exec: assert property (
    take && cmdOp == `FSB_OP_CHIP |=> doChipErase == rspAck && !doWrite && !doBlockErase)
    else $error("chip erase strobe wrong");
  a_block_exec: assert property (
    take && cmdOp == `FSB_OP_BLOCK |=> doBlockErase == rspAck && !doWrite && !doChipErase)
    else $error("block erase strobe wrong");
  a_op_addr: assert property (
    take |=> opAddr == $past(cmdAddr)) else $error("opAddr lost");
  a_store_stall: assert property (
    nvStore |-> !cmdReady) else $error("ready while storing");
  a_swap_map: assert property (
    up |=> mappedAddr == (($past(bootSwapped) && $past(fetchAddr) < 16'h2000) ?
    $past(fetchAddr) ^ 16'h1000 : $past(fetchAddr))) else $error("bad mapping");
  a_swap_steady: assert property (
    up |=> $stable(bootSwapped)) else $error("swap changed without reset");
endmodule

bind fsb_top fsb_top_props chk (.clock(clock), .rstn(rstn), .cmdValid(cmdValid),
  .cmdReady(cmdReady), .cmdOp(cmdOp), .cmdAddr(cmdAddr), .cmdSelf(cmdSelf),
  .rspAck(rspAck), .rspNak(rspNak), .doChipErase(doChipErase),
  .doBlockErase(doBlockErase), .doWrite(doWrite), .opAddr(opAddr), .nvStore(nvStore),
  .fetchAddr(fetchAddr), .mappedAddr(mappedAddr), .bootSwapped(bootSwapped));
`default_nettype wire
